/* File: design/usbp_phy_ctrl_regs.sv */
`timescale 1ns/100ps
module usbp_phy_ctrl_regs
  import usbp_pkg::*;
#(
  parameter logic [USBP_REV_W-1:0] SPEC_REV = USBP_REV_DEFAULT
)
(
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset,
  // avalon-mm slave
  input wire logic [USBP_AW-1:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [USBP_DW-1:0] i_writedata,
  input wire logic [USBP_BEW-1:0] i_byteenable,
  output logic [USBP_DW-1:0] o_readdata,
  output logic o_waitrequest,
  // transceiver static configuration
  output logic o_phy_suspend_release,
  output logic o_phy_power_save_input,
  output logic o_phy_reference_source_select,
  output logic [1:0] o_phy_reference_frequency_field,
  output logic o_phy_oscillator_keep_input,
  output logic o_phy_analog_power_down,
  output logic o_phy_oscillator_clock_source_select
);

  usbp_reg_if reg_bus ();

  logic [USBP_DW-1:0] ctrl_r;
  logic [USBP_DW-1:0] ctrl_nxt;
  logic [USBP_DW-1:0] be_mask;
  logic [USBP_DW-1:0] rdata;

  // ****************************************************************
  // bus front end
  // ****************************************************************
  usbp_avs_front u_front (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_address(i_address),
    .i_read(i_read),
    .i_write(i_write),
    .i_writedata(i_writedata),
    .i_byteenable(i_byteenable),
    .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest),
    .reg_bus(reg_bus.front)
  );

  // ****************************************************************
  // control register
  // ****************************************************************

  // expand byte enables to a bit mask, one lane per byte
  always_comb begin
    for (int i = 0; i < USBP_BEW; i++) begin
      be_mask[i*USBP_BYTE +: USBP_BYTE] = {USBP_BYTE{reg_bus.be[i]}};
    end
  end

  // merge only enabled lanes of implemented bits; reserved bits stay zero
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (reg_bus.wr_en && reg_bus.addr == USBP_ADDR_CTRL) begin
      ctrl_nxt = (ctrl_r & ~(be_mask & USBP_CTRL_WMASK))
               | (reg_bus.wdata & be_mask & USBP_CTRL_WMASK);
    end
  end

  // software values are stored as written; the hardware does not police
  // the fixed-value fields, so a wrong setting reaches the transceiver
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      ctrl_r <= USBP_CTRL_RESET; // suspend bit clear, transceiver held suspended
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // ****************************************************************
  // transceiver outputs, each a flop so nothing glitches on the pins
  // ****************************************************************
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      o_phy_suspend_release <= USBP_CTRL_RESET[USBP_BIT_SUSPEND];
      o_phy_power_save_input <= USBP_CTRL_RESET[USBP_BIT_PWR_SAVE];
      o_phy_reference_source_select <= USBP_CTRL_RESET[USBP_BIT_REF_SRC];
      o_phy_reference_frequency_field <= USBP_CTRL_RESET[USBP_FREQ_MSB:USBP_FREQ_LSB];
      o_phy_oscillator_keep_input <= USBP_CTRL_RESET[USBP_BIT_OSC_KEEP];
      o_phy_analog_power_down <= USBP_CTRL_RESET[USBP_BIT_ANA_PD];
      o_phy_oscillator_clock_source_select <= USBP_CTRL_RESET[USBP_BIT_OSC_SEL];
    end else begin
      o_phy_suspend_release <= ctrl_nxt[USBP_BIT_SUSPEND];
      o_phy_power_save_input <= ctrl_nxt[USBP_BIT_PWR_SAVE];
      o_phy_reference_source_select <= ctrl_nxt[USBP_BIT_REF_SRC];
      o_phy_reference_frequency_field <= ctrl_nxt[USBP_FREQ_MSB:USBP_FREQ_LSB];
      o_phy_oscillator_keep_input <= ctrl_nxt[USBP_BIT_OSC_KEEP];
      o_phy_analog_power_down <= ctrl_nxt[USBP_BIT_ANA_PD];
      o_phy_oscillator_clock_source_select <= ctrl_nxt[USBP_BIT_OSC_SEL];
    end
  end

  // ****************************************************************
  // read decode; unmapped addresses read zero and writes are dropped
  // ****************************************************************
  always_comb begin
    rdata = '0;
    case (reg_bus.addr)
      USBP_ADDR_CTRL: begin
        rdata = ctrl_r & USBP_CTRL_WMASK;
      end
      USBP_ADDR_REV: begin
        rdata[USBP_REV_W-1:0] = SPEC_REV; // no write path exists
      end
      default: begin
        rdata = '0;
      end
    endcase
  end

  assign reg_bus.rdata = rdata;

endmodule

/* File: design/usbp_pkg.sv */
package usbp_pkg;

  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam logic [31:0] USBP_ADDR_CTRL = 32'hB000_50C8;
  localparam logic [31:0] USBP_ADDR_REV = 32'hB000_7000;

  // ****************************************************************
  // control register fields
  // ****************************************************************
  localparam int USBP_BIT_OSC_SEL = 11;
  localparam int USBP_BIT_SUSPEND = 8;
  localparam int USBP_BIT_PWR_SAVE = 7;
  localparam int USBP_BIT_REF_SRC = 6;
  localparam int USBP_FREQ_MSB = 5;
  localparam int USBP_FREQ_LSB = 4;
  localparam int USBP_BIT_OSC_KEEP = 3;
  localparam int USBP_BIT_ANA_PD = 2;
  localparam logic [31:0] USBP_CTRL_RESET = 32'h0000_0020;
  localparam logic [31:0] USBP_CTRL_WMASK = 32'h0000_09FC;

  // ****************************************************************
  // version register fields
  // ****************************************************************
  localparam int USBP_REV_W = 8;
  // arbitrary value, not a real revision code
  localparam logic [7:0] USBP_REV_DEFAULT = 8'h01;

  // ****************************************************************
  // bus geometry
  // ****************************************************************
  localparam int USBP_DW = 32;
  localparam int USBP_AW = 32;
  localparam int USBP_BEW = 4;
  localparam int USBP_BYTE = 8;

endpackage

/* File: design/usbp_reg_if.sv */
`timescale 1ns/100ps
// carries decoded accesses from the bus front end to the register bank
interface usbp_reg_if;
  import usbp_pkg::*;
  logic wr_en;
  logic [USBP_AW-1:0] addr;
  logic [USBP_DW-1:0] wdata;
  logic [USBP_BEW-1:0] be;
  logic [USBP_DW-1:0] rdata;

  modport front (
    output wr_en,
    output addr,
    output wdata,
    output be,
    input rdata
  );
  modport bank (
    input wr_en,
    input addr,
    input wdata,
    input be,
    output rdata
  );
endinterface

/* File: design/usbp_avs_front.sv */
`timescale 1ns/100ps
// avalon-mm slave handshake: one wait state on every access
module usbp_avs_front
  import usbp_pkg::*;
(
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset,
  // avalon-mm slave
  input wire logic [USBP_AW-1:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [USBP_DW-1:0] i_writedata,
  input wire logic [USBP_BEW-1:0] i_byteenable,
  output logic [USBP_DW-1:0] o_readdata,
  output logic o_waitrequest,
  // register side
  usbp_reg_if.front reg_bus
);

  logic wait_r;
  logic [USBP_DW-1:0] rdata_r;
  logic req;

  // ****************************************************************
  // request path
  // ****************************************************************
  assign req = i_read | i_write;
  // write commits only at the edge where the master sees waitrequest low
  assign reg_bus.wr_en = i_write & ~wait_r;
  assign reg_bus.addr = i_address;
  assign reg_bus.wdata = i_writedata;
  assign reg_bus.be = i_byteenable;

  // waitrequest: high at rest, low for exactly one cycle per access
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      wait_r <= 1'b1;
    end else if (req && wait_r) begin
      wait_r <= 1'b0;
    end else begin
      wait_r <= 1'b1; // re-arm so back-to-back requests each see a wait
    end
  end

  // read data captured one cycle early so it stands while waitrequest is low
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      rdata_r <= '0;
    end else if (i_read && wait_r) begin
      rdata_r <= reg_bus.rdata;
    end
  end

  assign o_waitrequest = wait_r;
  assign o_readdata = rdata_r;

endmodule

/* File: verif/usbp_monitor.sv */
`timescale 1ns/100ps
module usbp_monitor
  import usbp_pkg::*;
#(
  parameter logic [USBP_REV_W-1:0] SPEC_REV = USBP_REV_DEFAULT
)
(
  // clock, reset and bus
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic [USBP_AW-1:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [USBP_DW-1:0] i_writedata,
  input wire logic [USBP_BEW-1:0] i_byteenable,
  input wire logic [USBP_DW-1:0] o_readdata,
  input wire logic o_waitrequest,
  // transceiver configuration
  input wire logic o_phy_suspend_release,
  input wire logic o_phy_power_save_input,
  input wire logic o_phy_reference_source_select,
  input wire logic [1:0] o_phy_reference_frequency_field,
  input wire logic o_phy_oscillator_keep_input,
  input wire logic o_phy_analog_power_down,
  input wire logic o_phy_oscillator_clock_source_select
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  // a control write commits at the edge where waitrequest is low
  wire cw = i_write && !o_waitrequest && i_address == USBP_ADDR_CTRL;
  wire [8:0] phy = {o_phy_oscillator_clock_source_select, o_phy_suspend_release,
    o_phy_power_save_input, o_phy_reference_source_select,
    o_phy_reference_frequency_field, o_phy_oscillator_keep_input, o_phy_analog_power_down};
  // ****************************************************************
  // read sequences
  // ****************************************************************
  sequence s_rev_rd;
    i_read && o_waitrequest && i_address == USBP_ADDR_REV ##1 !o_waitrequest;
  endsequence
  sequence s_ctl_rd;
    i_read && o_waitrequest && i_address == USBP_ADDR_CTRL ##1 !o_waitrequest;
  endsequence
  a_suspend_write: assert property (cw && i_byteenable[1] |=>
    o_phy_suspend_release == $past(i_writedata[8])) else $error("suspend mismatch");
  a_suspend_held: assert property ($rose(o_phy_suspend_release) |-> $past(cw))
    else $error("suspend released without write");
  a_psave_write: assert property (cw && i_byteenable[0] |=>
    o_phy_power_save_input == $past(i_writedata[7])) else $error("power save mismatch");
  a_osc_keep_write: assert property (cw && i_byteenable[0] |=>
    o_phy_oscillator_keep_input == $past(i_writedata[3])) else $error("osc keep mismatch");
  a_analog_pd_write: assert property (cw && i_byteenable[0] |=>
    o_phy_analog_power_down == $past(i_writedata[2])) else $error("analog pd mismatch");
  a_rev_readback: assert property (s_rev_rd |-> o_readdata == {24'h000000, SPEC_REV})
    else $error("version read mismatch");
  a_ctrl_reserved: assert property (s_ctl_rd |-> (o_readdata & ~USBP_CTRL_WMASK) == 0)
    else $error("reserved bits not zero");
  a_idle_stable: assert property (!cw |=> $stable(phy))
    else $error("phy output moved without write");
endmodule

bind usbp_phy_ctrl_regs usbp_monitor #(.SPEC_REV(SPEC_REV)) u_mon (.*);

/* File: verif/usbp_phy_model.sv */
`timescale 1ns/100ps
// behavioural transceiver: reports which blocks are powered
module usbp_phy_model (
  // configuration inputs
  input wire logic i_release,
  input wire logic i_power_save,
  input wire logic i_analog_pd,
  // power state
  output logic o_pll_on,
  output logic o_analog_on
);
  // pll runs only out of suspend and outside power-save
  assign o_pll_on = i_release && !i_power_save;
  // analog blocks need release and no quiescent test
  assign o_analog_on = i_release && !i_analog_pd;
endmodule

/* File: verif/usbp_phy_ctrl_regs_tb.sv */
`timescale 1ns/100ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_errors++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, a, e); end end
module usbp_phy_ctrl_regs_tb;
  import usbp_pkg::*;
  logic i_core_clk = 0, i_reset = 1, i_read = 0, i_write = 0;
  logic [31:0] i_address = 0, i_writedata = 0, o_readdata, rd, cur;
  logic [3:0] i_byteenable = 0;
  logic o_waitrequest, o_phy_suspend_release, o_phy_power_save_input;
  logic o_phy_reference_source_select, o_phy_oscillator_keep_input;
  logic o_phy_analog_power_down, o_phy_oscillator_clock_source_select;
  logic [1:0] o_phy_reference_frequency_field;
  logic pll, ana;
  int n_errors = 0, n_checks = 0;
  usbp_phy_ctrl_regs u_dut (.*);
  usbp_phy_model u_phy (.i_release(o_phy_suspend_release), .i_power_save(o_phy_power_save_input),
    .i_analog_pd(o_phy_analog_power_down), .o_pll_on(pll), .o_analog_on(ana));
  initial forever #5 i_core_clk = ~i_core_clk;
  // one bus access; request held until waitrequest is sampled low
  // no local limit: a slave that never answers is caught by the watchdog
  task automatic acc(input logic w, input logic [31:0] a, d, input logic [3:0] b);
    i_write <= w;
    i_read <= !w;
    i_address <= a;
    i_writedata <= d;
    i_byteenable <= b;
    do @(posedge i_core_clk); while (o_waitrequest !== 1'b0);
    rd = o_readdata;
    i_write <= 0;
    i_read <= 0;
    @(posedge i_core_clk);
  endtask
  // write the control register, then check pins and readback
  task automatic wchk(input logic [31:0] d, input logic [3:0] b);
    logic [31:0] m;
    logic [11:0] pins;
    m = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}} & USBP_CTRL_WMASK;
    cur = (cur & ~m) | (d & m);
    acc(1, USBP_ADDR_CTRL, d, b);
    pins = {o_phy_oscillator_clock_source_select, 2'b00, o_phy_suspend_release,
      o_phy_power_save_input, o_phy_reference_source_select, o_phy_reference_frequency_field,
      o_phy_oscillator_keep_input, o_phy_analog_power_down, 2'b00};
    `CHK(pins, cur[11:0])
    acc(0, USBP_ADDR_CTRL, 0, 4'hF);
    `CHK(rd, cur)
  endtask
  task t_reset;
    cur = USBP_CTRL_RESET;
    acc(0, USBP_ADDR_CTRL, 0, 4'hF);
    `CHK(rd, 32'h0000_0020)
    `CHK(o_phy_suspend_release, 1'b0)
  endtask
  task t_ctrl;
    wchk(32'h0000_0120, 4'h3);
    `CHK(pll, 1'b1)
    wchk(32'h0000_01A0, 4'h3);
    `CHK(pll, 1'b0)
    wchk(32'h0000_0124, 4'h3);
    `CHK(ana, 1'b0)
    wchk(32'h0000_0128, 4'h3);
    wchk(32'hFFFF_FFFF, 4'h1);
    wchk(32'hFFFF_FFFF, 4'h2);
    wchk(32'h0000_0020, 4'hF);
  endtask
  task t_rev;
    acc(1, USBP_ADDR_REV, 32'hFFFF_FFFF, 4'hF);
    acc(0, USBP_ADDR_REV, 0, 4'hF);
    `CHK(rd, {24'h000000, USBP_REV_DEFAULT})
    acc(0, 32'hB000_7010, 0, 4'hF);
    `CHK(rd, 32'h0000_0000)
  endtask
  task give_verdict;
    if (n_errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge i_core_clk);
    i_reset <= 0;
    @(posedge i_core_clk);
    t_reset();
    t_ctrl();
    t_rev();
    give_verdict();
  end
  // watchdog: the whole run needs well under 200 cycles
  initial begin
    #100us;
    n_errors++;
    give_verdict();
  end
endmodule
